// [dmc_mode_regs.v]
// Purpose: Mode-control register bank of a dual interpolating DAC.
// Assumes: All inputs synchronous to clk; serial clock far below clk.
// Notes:   Register 00h survives a software reset; only rst_n clears it.
//
// Summary of operation
// - Bit 7 of 00h enables data pin output.
// - Bit 6 of 00h picks LSB-first order.
// - Writing bit 5 of 00h resets registers.
// - Bit 4 of 00h sleeps, DAC currents off.
// - Bit 3 of 00h powers down the device.
// - Bit 2 of 00h picks one-resistor reference.
// - Bit 1 of 00h reads PLL lock.
// - Bits 7:6 of 01h set interpolation rate.
// - Bit 3 of 01h enables zero stuffing.
// - Bit 2 of 01h selects real mixing.
// - Bit 0 of 01h selects shared pin source.
// - Bit 7 of 02h selects unsigned input.
// - Bit 6 of 02h selects one-port mode.
// - Bits 5:4 of 02h: clock drive, inversion.
// - Bit 2 of 02h inverts interleave clock.
// - Bit 1 of 02h inverts channel select.
// - Bit 0 of 02h puts Q first.
// - 03h holds prescaler and rate clock bit.
// - Bit 7 of 04h turns PLL on.
// - Bit 6 of 04h picks manual pump control.
// - Reset bit reads zero, spares 00h.
// - Serial port keeps working in power-down.
// - Lock bit valid only with PLL on.
`timescale 1ns/10ps
`include "dmc_consts.vh"

module dmc_mode_regs (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Serial control port
  input  wire       ser_sel_n,
  input  wire       ser_clk,
  input  wire       ser_data_pin_in,
  output wire       ser_data_pin_out,
  output wire       ser_data_pin_oe,
  output wire       ser_dout_out,
  output wire       ser_dout_oe,
  // Status and clock sources from the datapath
  input  wire       pll_lock_in,
  input  wire       data_rate_clk_src,
  input  wire       interleave_clk_src,
  input  wire       channel_select_in,
  // Pin-level results
  output reg        data_rate_clock_out,
  output reg        interleave_clock_out,
  output reg        channel_select,
  output reg        shared_pin_out,
  output reg        lock_indicator,
  // Power control
  output reg        dac_current_off,
  output wire       power_down,
  output wire       one_resistor_mode,
  output reg        soft_reset_pulse,
  // Filter and modulation settings
  output wire [1:0] interp_rate,
  output wire [1:0] mod_mode,
  output wire       mod_sign_pos,
  output wire       zero_stuff_en,
  output wire       real_mix,
  // Data port settings
  output wire       unsigned_data,
  output wire       one_port_mode,
  output wire       drc_drive_strong,
  output wire       q_first,
  // PLL settings
  output wire       drc_ctl,
  output wire [1:0] pll_div,
  output wire       pll_on,
  output wire       pump_manual,
  output wire [2:0] pump_ctl
);

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  reg  [7:0] port_and_power_control;
  reg  [7:0] filter_and_modulation_control;
  reg  [7:0] input_data_format_control;
  reg  [7:0] pll_divider_control;
  reg  [7:0] pll_enable_and_pump_control;

  wire       wr_stb;
  wire [4:0] wr_addr;
  wire [7:0] wr_data;
  wire [4:0] rd_addr;
  reg  [7:0] rd_data;

  wire       soft_reset_req;

  // ----------------------------------------------------------------------
  // Serial control port
  // ----------------------------------------------------------------------
  // The port has no power gating, so registers stay reachable even while
  // power-down holds the rest of the device off.
  dmc_serial_port u_port (
    .clk       (clk),
    .rst_n     (rst_n),
    .sel_n     (ser_sel_n),
    .sclk      (ser_clk),
    .din       (ser_data_pin_in),
    .sdio_out  (ser_data_pin_out),
    .sdio_oe   (ser_data_pin_oe),
    .sdo_out   (ser_dout_out),
    .sdo_oe    (ser_dout_oe),
    .lsb_first (port_and_power_control[`DMC_B_LSB_FIRST]),
    .bidir     (port_and_power_control[`DMC_B_BIDIR]),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .wr_stb    (wr_stb),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data)
  );

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  assign soft_reset_req = wr_stb && wr_addr == `DMC_ADDR_PORT_PWR &&
                          wr_data[`DMC_B_SOFT_RST];

  // Register 00h is never touched by the software reset; otherwise the
  // write that requests it would undo its own port settings.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_and_power_control <= `DMC_RST_PORT_PWR;
    end else if (wr_stb && wr_addr == `DMC_ADDR_PORT_PWR) begin
      port_and_power_control <= wr_data & `DMC_MASK_PORT_PWR;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filter_and_modulation_control <= `DMC_RST_FILT_MOD;
      input_data_format_control     <= `DMC_RST_DATA_FMT;
      pll_divider_control           <= `DMC_RST_PLL_DIV;
      pll_enable_and_pump_control   <= `DMC_RST_PLL_PUMP;
    end else if (soft_reset_req) begin
      filter_and_modulation_control <= `DMC_RST_FILT_MOD;
      input_data_format_control     <= `DMC_RST_DATA_FMT;
      pll_divider_control           <= `DMC_RST_PLL_DIV;
      pll_enable_and_pump_control   <= `DMC_RST_PLL_PUMP;
    end else if (wr_stb) begin
      case (wr_addr)
        `DMC_ADDR_FILT_MOD: begin
          filter_and_modulation_control <= wr_data & `DMC_MASK_FILT_MOD;
        end
        `DMC_ADDR_DATA_FMT: begin
          input_data_format_control <= wr_data & `DMC_MASK_DATA_FMT;
        end
        `DMC_ADDR_PLL_DIV: begin
          pll_divider_control <= wr_data & `DMC_MASK_PLL_DIV;
        end
        `DMC_ADDR_PLL_PUMP: begin
          pll_enable_and_pump_control <= wr_data & `DMC_MASK_PLL_PUMP;
        end
        default: begin
          filter_and_modulation_control <= filter_and_modulation_control;
        end
      endcase
    end
  end

  // The restart pulse lets the datapath flush state along with the bank.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= soft_reset_req;
    end
  end

  // ----------------------------------------------------------------------
  // Register readback
  // ----------------------------------------------------------------------
  always @* begin
    case (rd_addr)
      `DMC_ADDR_PORT_PWR: begin
        rd_data = port_and_power_control;
        rd_data[`DMC_B_LOCK] = lock_indicator;
      end
      `DMC_ADDR_FILT_MOD: begin
        rd_data = filter_and_modulation_control;
      end
      `DMC_ADDR_DATA_FMT: begin
        rd_data = input_data_format_control;
      end
      `DMC_ADDR_PLL_DIV: begin
        rd_data = pll_divider_control;
      end
      `DMC_ADDR_PLL_PUMP: begin
        rd_data = pll_enable_and_pump_control;
      end
      default: begin
        rd_data = 8'h00;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------------
  assign power_down        = port_and_power_control[`DMC_B_PWR_DOWN];
  assign one_resistor_mode = port_and_power_control[`DMC_B_ONE_RES];

  assign interp_rate   = filter_and_modulation_control[`DMC_F_INTERP];
  assign mod_mode      = filter_and_modulation_control[`DMC_F_MOD];
  assign mod_sign_pos  = filter_and_modulation_control[`DMC_B_MOD_SIGN];
  assign zero_stuff_en = filter_and_modulation_control[`DMC_B_ZSTUFF];
  assign real_mix      = filter_and_modulation_control[`DMC_B_REAL_MIX];

  assign unsigned_data    = input_data_format_control[`DMC_B_UNSIGNED];
  assign one_port_mode    = input_data_format_control[`DMC_B_ONE_PORT];
  assign drc_drive_strong = input_data_format_control[`DMC_B_DRC_DRIVE];
  assign q_first          = input_data_format_control[`DMC_B_Q_FIRST];

  assign drc_ctl     = pll_divider_control[`DMC_B_DRC_CTL];
  assign pll_div     = pll_divider_control[`DMC_F_PLL_DIV];
  assign pll_on      = pll_enable_and_pump_control[`DMC_B_PLL_ON];
  assign pump_manual = pll_enable_and_pump_control[`DMC_B_PUMP_MANUAL];
  // Automatic control hides the programmed pump setting from the PLL.
  assign pump_ctl    = pump_manual ?
                       pll_enable_and_pump_control[`DMC_F_PUMP] : 3'h0;

  // ----------------------------------------------------------------------
  // Pin-level outputs
  // ----------------------------------------------------------------------
  // Each pin is retimed once, which costs one clk of delay on the clock
  // outputs but keeps them glitch free when an invert bit changes.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_rate_clock_out  <= 1'b0;
      interleave_clock_out <= 1'b0;
      channel_select       <= 1'b0;
      shared_pin_out       <= 1'b0;
      lock_indicator       <= 1'b0;
      dac_current_off      <= 1'b0;
    end else begin
      data_rate_clock_out  <= data_rate_clk_src ^
                              input_data_format_control[`DMC_B_DRC_INV];
      interleave_clock_out <= interleave_clk_src ^
                              input_data_format_control[`DMC_B_ILV_INV];
      channel_select       <= channel_select_in ^
                              input_data_format_control[`DMC_B_CSEL_INV];
      // Lock is reported only while the PLL runs, otherwise it is noise.
      lock_indicator       <= pll_lock_in & pll_on;
      shared_pin_out       <=
        filter_and_modulation_control[`DMC_B_SHARED_SEL] ?
        (data_rate_clk_src ^ input_data_format_control[`DMC_B_DRC_INV]) :
        (pll_lock_in & pll_on);
      // Power-down implies the output currents are off as well.
      dac_current_off      <= port_and_power_control[`DMC_B_SLEEP] |
                              port_and_power_control[`DMC_B_PWR_DOWN];
    end
  end

endmodule

// [dmc_consts.vh]
// Purpose: Constants of the DAC mode-control register bank.
// Assumes: Included by the design files by bare name.
// Notes:   Offsets, field positions, write masks and reset values only.
`ifndef DMC_CONSTS_VH
`define DMC_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DMC_ADDR_PORT_PWR      5'h00
`define DMC_ADDR_FILT_MOD      5'h01
`define DMC_ADDR_DATA_FMT      5'h02
`define DMC_ADDR_PLL_DIV       5'h03
`define DMC_ADDR_PLL_PUMP      5'h04

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DMC_RST_PORT_PWR       8'h00
`define DMC_RST_FILT_MOD       8'h04
`define DMC_RST_DATA_FMT       8'h00
`define DMC_RST_PLL_DIV        8'h00
`define DMC_RST_PLL_PUMP       8'h00

// ----------------------------------------------------------------------
// Stored bits of each register
// ----------------------------------------------------------------------
`define DMC_MASK_PORT_PWR      8'hDC
`define DMC_MASK_FILT_MOD      8'hFF
`define DMC_MASK_DATA_FMT      8'hF7
`define DMC_MASK_PLL_DIV       8'h83
`define DMC_MASK_PLL_PUMP      8'hC7

// ----------------------------------------------------------------------
// Field positions, port and power register
// ----------------------------------------------------------------------
`define DMC_B_BIDIR            7
`define DMC_B_LSB_FIRST        6
`define DMC_B_SOFT_RST         5
`define DMC_B_SLEEP            4
`define DMC_B_PWR_DOWN         3
`define DMC_B_ONE_RES          2
`define DMC_B_LOCK             1

// ----------------------------------------------------------------------
// Field positions, filter and modulation register
// ----------------------------------------------------------------------
`define DMC_F_INTERP           7:6
`define DMC_F_MOD              5:4
`define DMC_B_ZSTUFF           3
`define DMC_B_REAL_MIX         2
`define DMC_B_MOD_SIGN         1
`define DMC_B_SHARED_SEL       0

// ----------------------------------------------------------------------
// Field positions, data format register
// ----------------------------------------------------------------------
`define DMC_B_UNSIGNED         7
`define DMC_B_ONE_PORT         6
`define DMC_B_DRC_DRIVE        5
`define DMC_B_DRC_INV          4
`define DMC_B_ILV_INV          2
`define DMC_B_CSEL_INV         1
`define DMC_B_Q_FIRST          0

// ----------------------------------------------------------------------
// Field positions, PLL registers
// ----------------------------------------------------------------------
`define DMC_B_DRC_CTL          7
`define DMC_F_PLL_DIV          1:0
`define DMC_B_PLL_ON           7
`define DMC_B_PUMP_MANUAL      6
`define DMC_F_PUMP             2:0

`endif

// [dmc_serial_port.v]
// Purpose: Serial control port framing: instruction, data bytes, readout.
// Assumes: Port pins are synchronous to clk; each serial clock level
//          lasts at least two clk periods.
// Notes:   Reads fetch register data one clk after the byte boundary.
`timescale 1ns/10ps
`include "dmc_consts.vh"

module dmc_serial_port (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Serial pins
  input  wire       sel_n,
  input  wire       sclk,
  input  wire       din,
  output reg        sdio_out,
  output reg        sdio_oe,
  output reg        sdo_out,
  output reg        sdo_oe,
  // Port configuration
  input  wire       lsb_first,
  input  wire       bidir,
  // Register access
  output reg  [4:0] rd_addr,
  input  wire [7:0] rd_data,
  output reg        wr_stb,
  output reg  [4:0] wr_addr,
  output reg  [7:0] wr_data
);

  localparam PH_INSTR = 2'b00;
  localparam PH_DATA  = 2'b01;
  localparam PH_DONE  = 2'b10;

  reg       sclk_q;
  reg [1:0] phase;
  reg [2:0] bit_cnt;
  reg       is_read;
  reg [1:0] bytes_left;
  reg [7:0] shift_in;
  reg [7:0] shift_out;
  reg       load_pend;

  wire       rise = sclk & ~sclk_q;
  wire       fall = ~sclk & sclk_q;
  wire [7:0] next_in = lsb_first ? {din, shift_in[7:1]} :
                                   {shift_in[6:0], din};
  wire [4:0] next_addr = lsb_first ? rd_addr + 5'h01 : rd_addr - 5'h01;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q     <= 1'b0;
      phase      <= PH_INSTR;
      bit_cnt    <= 3'h0;
      is_read    <= 1'b0;
      bytes_left <= 2'h0;
      shift_in   <= 8'h00;
      shift_out  <= 8'h00;
      load_pend  <= 1'b0;
      rd_addr    <= 5'h00;
      wr_stb     <= 1'b0;
      wr_addr    <= 5'h00;
      wr_data    <= 8'h00;
      sdio_out   <= 1'b0;
      sdio_oe    <= 1'b0;
      sdo_out    <= 1'b0;
      sdo_oe     <= 1'b0;
    end else begin
      sclk_q <= sclk;
      wr_stb <= 1'b0;
      if (load_pend) begin
        shift_out <= rd_data;
        load_pend <= 1'b0;
      end
      // A high select aborts any cycle and restarts at the instruction.
      if (sel_n) begin
        phase   <= PH_INSTR;
        bit_cnt <= 3'h0;
        sdio_oe <= 1'b0;
        sdo_oe  <= 1'b0;
      end else begin
        if (rise && phase != PH_DONE) begin
          shift_in <= next_in;
          bit_cnt  <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            if (phase == PH_INSTR) begin
              is_read    <= next_in[7];
              bytes_left <= next_in[6:5];
              rd_addr    <= next_in[4:0];
              load_pend  <= next_in[7];
              phase      <= PH_DATA;
            end else begin
              wr_stb    <= ~is_read;
              wr_addr   <= rd_addr;
              wr_data   <= next_in;
              rd_addr   <= next_addr;
              load_pend <= is_read;
              if (bytes_left == 2'h0)
                phase <= PH_DONE;
              else
                bytes_left <= bytes_left - 2'h1;
            end
          end
        end
        if (fall && phase == PH_DATA && is_read) begin
          sdio_out  <= lsb_first ? shift_out[0] : shift_out[7];
          sdo_out   <= lsb_first ? shift_out[0] : shift_out[7];
          shift_out <= lsb_first ? {1'b0, shift_out[7:1]} :
                                   {shift_out[6:0], 1'b0};
          // The data pin only turns round when software allowed it.
          sdio_oe   <= bidir;
          sdo_oe    <= ~bidir;
        end else if (fall && phase != PH_DATA) begin
          sdio_oe <= 1'b0;
          sdo_oe  <= 1'b0;
        end
      end
    end
  end

endmodule

// [dmc_mode_props.sv]
// Purpose: Concurrent checks on the ports of the mode-control registers.
// Assumes: Bound to dmc_mode_regs; one clock domain.
// Notes:   Register bits that are not ports are checked by the bench.
`timescale 1ns/10ps
module dmc_mode_props (
  // Clock and reset
  input logic       clk,
  input logic       rst_n,
  // Serial port
  input logic       ser_sel_n,
  input logic       ser_data_pin_oe,
  input logic       ser_dout_oe,
  // Pin sources
  input logic       pll_lock_in,
  input logic       data_rate_clk_src,
  input logic       interleave_clk_src,
  input logic       channel_select_in,
  // Pin results
  input logic       data_rate_clock_out,
  input logic       interleave_clock_out,
  input logic       channel_select,
  input logic       lock_indicator,
  // Settings
  input logic       dac_current_off,
  input logic       power_down,
  input logic       soft_reset_pulse,
  input logic [1:0] interp_rate,
  input logic [1:0] mod_mode,
  input logic       real_mix,
  input logic       pll_on,
  input logic       pump_manual,
  input logic [2:0] pump_ctl
);
  // --------------------------------------------------------------------
  // Source history
  // --------------------------------------------------------------------
  logic       drc_q;
  logic       ilv_q;
  logic       csel_q;
  logic [2:0] inv_x;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drc_q  <= 1'h0;
      ilv_q  <= 1'h0;
      csel_q <= 1'h0;
    end else begin
      drc_q  <= data_rate_clk_src;
      ilv_q  <= interleave_clk_src;
      csel_q <= channel_select_in;
    end
  end

  // Output XOR its source a clock earlier is the inversion setting, which
  // may only move while a serial write is in progress.
  assign inv_x = {data_rate_clock_out ^ drc_q,
                  interleave_clock_out ^ ilv_q,
                  channel_select ^ csel_q};

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_oe_exclusive: assert property (
    !(ser_data_pin_oe && ser_dout_oe))
    else $error("Both serial outputs enabled.");
  a_oe_idle: assert property (
    ser_sel_n [*3] |-> !ser_dout_oe && !ser_data_pin_oe)
    else $error("Serial output enabled while deselected.");
  a_inv_steady: assert property (
    ser_sel_n [*3] |-> $stable(inv_x))
    else $error("Inversion changed without a write.");
  a_lock_gate: assert property (
    lock_indicator == ($past(pll_lock_in) && $past(pll_on)))
    else $error("Lock indicator not lock and PLL on.");
  a_pump_auto: assert property (
    !pump_manual |-> pump_ctl == 3'h0)
    else $error("Pump control set in automatic mode.");
  a_dac_off: assert property (
    power_down |=> dac_current_off)
    else $error("DAC currents on in power-down.");
  a_soft_pulse: assert property (
    soft_reset_pulse |=> !soft_reset_pulse)
    else $error("Software reset pulse too long.");
  a_soft_defaults: assert property (
    soft_reset_pulse |-> ##[0:2] (interp_rate == 2'h0 && mod_mode == 2'h0
      && real_mix && !pll_on && pump_ctl == 3'h0))
    else $error("Registers not at defaults after software reset.");
endmodule

bind dmc_mode_regs dmc_mode_props dmc_mode_props_inst (
  .clk, .rst_n, .ser_sel_n, .ser_data_pin_oe, .ser_dout_oe, .pll_lock_in,
  .data_rate_clk_src, .interleave_clk_src, .channel_select_in,
  .data_rate_clock_out, .interleave_clock_out, .channel_select,
  .lock_indicator, .dac_current_off, .power_down, .soft_reset_pulse,
  .interp_rate, .mod_mode, .real_mix, .pll_on, .pump_manual, .pump_ctl
);

// [dmc_host_model.sv]
// Purpose: Host controller model driving the serial control port.
// Assumes: Called from the bench just after a falling clock edge.
// Notes:   Serial clock idles low; each level lasts four clocks.
`timescale 1ns/10ps
module dmc_host_model (
  // Clock
  input  logic clk,
  // Serial pins
  output logic sel_n,
  output logic sck,
  output logic host_d,
  input  logic line_d,
  input  logic pin_oe,
  input  logic dout_oe
);
  logic seen_pin;
  logic seen_dout;

  initial begin
    sel_n = 1'h1;
    sck = 1'h0;
    host_d = 1'h0;
    seen_pin = 1'h0;
    seen_dout = 1'h0;
  end

  // One bit: set while the clock is low, read late in the low phase.
  task automatic bit_io(input logic drv, input logic v, output logic got);
    sck = 1'h0;
    host_d = drv ? v : ~host_d;
    repeat (4) @(negedge clk);
    got = line_d;
    seen_pin = seen_pin | pin_oe;
    seen_dout = seen_dout | dout_oe;
    sck = 1'h1;
    repeat (4) @(negedge clk);
  endtask

  task automatic xfer(input logic rd, input logic [4:0] a,
                      input logic [1:0] n, input logic lsb,
                      input logic [31:0] wd, output logic [31:0] rdv);
    logic [7:0] ins;
    logic       g;
    int         k;
    ins = {rd, n, a};
    rdv = 32'h0;
    seen_pin = 1'h0;
    seen_dout = 1'h0;
    sel_n = 1'h0;
    repeat (2) @(negedge clk);
    for (int i = 0; i < 8; i++) bit_io(1'h1, ins[lsb ? i : 7 - i], g);
    for (int j = 0; j <= n; j++) begin
      for (int i = 0; i < 8; i++) begin
        k = 8 * j + (lsb ? i : 7 - i);
        bit_io(!rd, wd[k], g);
        rdv[k] = g;
      end
    end
    sck = 1'h0;
    repeat (4) @(negedge clk);
    sel_n = 1'h1;
    repeat (4) @(negedge clk);
  endtask
endmodule

// [dmc_mode_regs_tb.sv]
// Purpose: Self-checking bench for the mode-control register bank.
// Assumes: Inputs change at the falling clock edge.
// Notes:   Serial accesses go through the host model's transfer task.
`timescale 1ns/10ps
module dmc_mode_regs_tb;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic pll_lock_in, data_rate_clk_src, interleave_clk_src;
  logic channel_select_in, lsb, ser_sel_n, ser_clk, host_d;
  logic ser_data_pin_out, ser_data_pin_oe, ser_dout_out, ser_dout_oe;
  logic data_rate_clock_out, interleave_clock_out, channel_select;
  logic shared_pin_out, lock_indicator, dac_current_off, power_down;
  logic one_resistor_mode, soft_reset_pulse, mod_sign_pos, zero_stuff_en;
  logic real_mix, unsigned_data, one_port_mode, drc_drive_strong, q_first;
  logic drc_ctl, pll_on, pump_manual;
  logic [1:0] interp_rate, mod_mode, pll_div;
  logic [2:0] pump_ctl;
  logic [31:0] rv;
  int err_total = 0;
  int checks_done = 0;
  wire ser_data_pin_in = ser_data_pin_oe ? ser_data_pin_out : host_d;
  wire line_d = ser_data_pin_oe ? ser_data_pin_out : ser_dout_out;

  always #20 clk = ~clk;

  dmc_mode_regs dmc_mode_regs_inst (
    .clk, .rst_n, .ser_sel_n, .ser_clk, .ser_data_pin_in, .ser_data_pin_out,
    .ser_data_pin_oe, .ser_dout_out, .ser_dout_oe, .pll_lock_in,
    .data_rate_clk_src, .interleave_clk_src, .channel_select_in,
    .data_rate_clock_out, .interleave_clock_out, .channel_select,
    .shared_pin_out, .lock_indicator, .dac_current_off, .power_down,
    .one_resistor_mode, .soft_reset_pulse, .interp_rate, .mod_mode,
    .mod_sign_pos, .zero_stuff_en, .real_mix, .unsigned_data,
    .one_port_mode, .drc_drive_strong, .q_first, .drc_ctl, .pll_div,
    .pll_on, .pump_manual, .pump_ctl);

  dmc_host_model dmc_host_model_inst (
    .clk, .sel_n(ser_sel_n), .sck(ser_clk), .host_d, .line_d,
    .pin_oe(ser_data_pin_oe), .dout_oe(ser_dout_oe));

  // ----------------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    dmc_host_model_inst.xfer(1'h0, a, 2'h0, lsb, {24'h0, d}, rv);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    dmc_host_model_inst.xfer(1'h1, a, 2'h0, lsb, 32'h0, rv);
    chk(rv[7:0], e);
  endtask

  task automatic conclude;
    if (err_total == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    #2000000;
    err_total++;
    conclude();
  end

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    {pll_lock_in, data_rate_clk_src, interleave_clk_src} = 3'h0;
    channel_select_in = 1'h0;
    lsb = 1'h0;
    repeat (6) @(negedge clk);
    rst_n = 1'h1;
    @(negedge clk);
    chk({interp_rate, real_mix, pll_on, pump_ctl, dac_current_off}, 8'h20);
    for (int a = 0; a < 6; a++) rd_chk(a[4:0], a == 1 ? 8'h04 : 8'h00);
    for (int v = 0; v < 4; v++) begin
      wr(5'h01, {v[1:0], v[1:0], 4'h8});
      chk({interp_rate, mod_mode, zero_stuff_en, real_mix, 2'h0},
          {v[1:0], v[1:0], 4'h8});
    end
    wr(5'h02, 8'hFF);
    rd_chk(5'h02, 8'hF7);
    chk({unsigned_data, one_port_mode, drc_drive_strong, q_first, 4'h0},
        8'hF0);
    wr(5'h03, 8'hFF);
    rd_chk(5'h03, 8'h83);
    chk({drc_ctl, pll_div, 5'h0}, 8'hE0);
    wr(5'h04, 8'hFF);
    rd_chk(5'h04, 8'hC7);
    chk({pll_on, pump_manual, pump_ctl, 3'h0}, 8'hF8);
    wr(5'h04, 8'h87);
    chk({pll_on, pump_manual, pump_ctl, 3'h0}, 8'h80);
    {data_rate_clk_src, interleave_clk_src, channel_select_in} = 3'h7;
    repeat (2) @(negedge clk);
    chk({data_rate_clock_out, interleave_clock_out, channel_select, 5'h0},
        8'h00);
    wr(5'h02, 8'h00);
    chk({data_rate_clock_out, interleave_clock_out, channel_select, 5'h0},
        8'hE0);
    pll_lock_in = 1'h1;
    wr(5'h01, 8'h04);
    chk({lock_indicator, shared_pin_out, 6'h0}, 8'hC0);
    rd_chk(5'h00, 8'h02);
    wr(5'h04, 8'h00);
    rd_chk(5'h00, 8'h00);
    chk({7'h0, lock_indicator}, 8'h00);
    wr(5'h00, 8'h18);
    chk({dac_current_off, power_down, one_resistor_mode, 5'h0}, 8'hC0);
    rd_chk(5'h00, 8'h18);
    wr(5'h00, 8'h10);
    chk({dac_current_off, power_down, one_resistor_mode, 5'h0}, 8'h80);
    wr(5'h00, 8'h04);
    chk({dac_current_off, power_down, one_resistor_mode, 5'h0}, 8'h20);
    wr(5'h01, 8'hFF);
    chk({mod_sign_pos, shared_pin_out, 6'h0}, 8'hC0);
    wr(5'h00, 8'h24);
    rd_chk(5'h00, 8'h04);
    rd_chk(5'h01, 8'h04);
    wr(5'h00, 8'hE4);
    lsb = 1'h1;
    rd_chk(5'h00, 8'hC4);
    chk({dmc_host_model_inst.seen_pin, dmc_host_model_inst.seen_dout,
         6'h0}, 8'h80);
    wr(5'h02, 8'h81);
    rd_chk(5'h02, 8'h81);
    chk({unsigned_data, q_first, 6'h0}, 8'hC0);
    dmc_host_model_inst.xfer(1'h0, 5'h03, 2'h1, lsb, 32'h8083, rv);
    chk({pll_on, pll_div, drc_ctl, 4'h0}, 8'hF0);
    wr(5'h00, 8'h00);
    lsb = 1'h0;
    rd_chk(5'h00, 8'h02);
    chk({dmc_host_model_inst.seen_pin, dmc_host_model_inst.seen_dout,
         6'h0}, 8'h40);
    dmc_host_model_inst.xfer(1'h1, 5'h02, 2'h1, lsb, 32'h0, rv);
    chk(rv[15:8], 8'h04);
    chk(rv[7:0], 8'h81);
    wr(5'h00, 8'h1C);
    rst_n = 1'h0;
    repeat (2) @(negedge clk);
    rst_n = 1'h1;
    repeat (2) @(negedge clk);
    rd_chk(5'h00, 8'h00);
    rd_chk(5'h03, 8'h00);
    conclude();
  end
endmodule
